// >>> src/camac_lam_and_readout_filter.v
// Look-at-me request, readout word filter and readout enable pass-through.
`default_nettype none
`include "camac_lam_regs.vh"

// Function
// - In sequential readout with overflow suppression and compression both on, words below one and overflow words are left out of readout.
// - A dataway initialize selects sequential readout and turns on pedestal subtraction and compression.
// - The request stays low whenever the request enable bit is off, whatever the data state.
// - With the request enable bit on, the request rises as soon as converted data become available.
// - In sequential readout the request drops once the last data word of the event is read.
// - Function 8 at subaddress 0 answers Q high when a request is pending and low otherwise, leaving the request alone.
// - Function 10 at subaddress 0 answers Q high when a request is pending and then clears it at the strobe.
// - A front-panel clear, or initialize, clear or function 9 at subaddress 0 at the strobe, clears the request.
// - A dataway initialize turns the request enable bit on.
// - The readout enable enters the first module and each module passes it on to the next through its pass output while it has no data to send.
// - With compression on in sequential readout, words below one are dropped and readout gives no Q when no valid word exists.
// - Sequential select 0 reads the channel named by the subaddress, select 1 reads in sequence and ignores it.
module camac_lam_and_readout_filter
(
   input  wire        sys_clk,
   input  wire        rst_n,
   // Register port.
   input  wire [7:0]  busAddr,
   input  wire [31:0] busWrData,
   input  wire        busWr,
   input  wire        busRd,
   output wire [31:0] busRdData,
   output wire        irq,
   // Dataway pins.
   input  wire        stationSel,
   input  wire        strobeS2,
   input  wire [4:0]  funcCode,
   input  wire [3:0]  subAddr,
   input  wire        initLine,
   input  wire        clearLine,
   input  wire        frontClear,
   output wire        lamRequest,
   output wire        qResponse,
   output wire [15:0] readWord,
   // Readout enable chain.
   input  wire        readoutEnableIn,
   output wire        enablePassthroughOut,
   // Converter side, same clock.
   input  wire        wordWrite,
   input  wire [3:0]  wordChan,
   input  wire [10:0] wordValue,
   input  wire        wordOverflow,
   input  wire        dataReady,
   output wire        pedestalSubtract
);

   // ============================================================
   // Pin synchronisers
   localparam PINS = 15;

   wire [PINS-1:0] pinRaw;
   reg  [PINS-1:0] pinMeta_r;
   reg  [PINS-1:0] pinSync_r;
   reg  [PINS-1:0] pinPrev_r;

   assign pinRaw = {frontClear, readoutEnableIn, clearLine, initLine,
                    stationSel, strobeS2, funcCode, subAddr};

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pinMeta_r <= {PINS{1'b0}};
         pinSync_r <= {PINS{1'b0}};
         pinPrev_r <= {PINS{1'b0}};
      end
      else
      begin
         pinMeta_r <= pinRaw;
         pinSync_r <= pinMeta_r;
         pinPrev_r <= pinSync_r;
      end
   end

   wire [3:0] aS      = pinSync_r[3:0];
   wire [4:0] fS      = pinSync_r[8:4];
   wire       s2Rise  = pinSync_r[9] & ~pinPrev_r[9];
   wire       nS      = pinSync_r[10];
   wire       zS      = pinSync_r[11];
   wire       cS      = pinSync_r[12];
   wire       renS    = pinSync_r[13];
   wire       fpRise  = pinSync_r[14] & ~pinPrev_r[14];

   // ============================================================
   // Control and state registers
   reg        ovfSuppress_r;
   reg        compressEn_r;
   reg        ped_r;
   reg        seq_r;
   reg        lamEn_r;
   reg [7:0]  vsn_r;
   reg        lamPending_r;
   reg        dataAvail_r;
   reg        hdrDone_r;
   reg [4:0]  seqPtr_r;
   reg [`IRQ_WIDTH-1:0] irqStat_r;
   reg [`IRQ_WIDTH-1:0] irqEn_r;
   reg        irq_r;
   reg        lamOut_r;
   reg        qOut_r;
   reg [15:0] readWord_r;
   reg [31:0] rdData_r;
   reg        pass_r;

   // Bit 11 holds the overflow flag, bits 10:0 the value.
   reg [11:0] wordMem [0:15];

   always @(posedge sys_clk)
   begin
      if (wordWrite)
         wordMem[wordChan] <= {wordOverflow, wordValue};
   end

   // ============================================================
   // Word filter
   function [4:0] firstValid;
      input [15:0] mask;
      input [4:0]  start;
      integer k;
      reg     found;
      begin
         firstValid = `NO_WORD;
         found = 1'b0;
         for (k = 0; k < 16; k = k + 1)
            if (!found && k >= start && mask[k])
            begin
               firstValid = k[4:0];
               found = 1'b1;
            end
      end
   endfunction

   function [4:0] countValid;
      input [15:0] mask;
      integer k;
      begin
         countValid = 5'h00;
         for (k = 0; k < 16; k = k + 1)
            countValid = countValid + {4'h0, mask[k]};
      end
   endfunction

   // Compression only acts in sequential mode.
   wire compressOn = compressEn_r & seq_r;
   wire [15:0] validMask;

   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1)
      begin : gFilter
         assign validMask[g] = ~compressOn |
                               ((wordMem[g][10:0] != 11'h000) &
                                ~(ovfSuppress_r & wordMem[g][11]));
      end
   endgenerate

   wire [4:0] wordCount = countValid(validMask);
   wire [4:0] curIdx    = firstValid(validMask, seqPtr_r);
   wire [4:0] curNext   = curIdx + 5'h01;
   wire [4:0] nextIdx   = firstValid(validMask, curNext);
   wire       withHdr   = compressOn & ~hdrDone_r;
   wire [11:0] curWord  = wordMem[curIdx[3:0]];
   wire [11:0] rndWord  = wordMem[aS];

   // ============================================================
   // Dataway command decode
   wire zCmd     = s2Rise & zS;
   wire cCmd     = s2Rise & cS;
   wire addr     = s2Rise & nS & ~zS & ~cS;
   wire subZero  = (aS == `SUBADDR_ZERO);
   wire fTest    = addr & (fS == `FN_TEST) & subZero;
   wire fClr     = addr & (fS == `FN_CLEAR) & subZero;
   wire fTestClr = addr & (fS == `FN_TEST_CLEAR) & subZero;
   wire fRead    = addr & (fS == `FN_READ);

   wire lamVisible = lamPending_r & lamEn_r;

   // random access always answers while data stand
   wire readOk  = dataAvail_r & (~seq_r | (curIdx != `NO_WORD));
   wire seqRead = fRead & readOk & seq_r;
   wire seqEnd  = seqRead & ~withHdr & (nextIdx == `NO_WORD);

   wire dataClear = zCmd | cCmd | fClr | fpRise;
   wire lamClear = dataClear | (fTestClr & lamVisible) | seqEnd;

   // ============================================================
   // Request flag and readout pointer
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lamPending_r <= 1'b0;
         dataAvail_r  <= 1'b0;
         hdrDone_r    <= 1'b0;
         seqPtr_r     <= 5'h00;
      end
      else
      begin
         if (lamClear)
            lamPending_r <= 1'b0;
         else if (dataReady)
            lamPending_r <= 1'b1;

         if (dataClear | seqEnd)
         begin
            dataAvail_r <= 1'b0;
            hdrDone_r   <= 1'b0;
            seqPtr_r    <= 5'h00;
         end
         else if (dataReady)
         begin
            dataAvail_r <= 1'b1;
            hdrDone_r   <= 1'b0;
            seqPtr_r    <= 5'h00;
         end
         else if (seqRead)
         begin
            if (withHdr)
               hdrDone_r <= 1'b1;
            else
               seqPtr_r <= curNext;
         end
      end
   end

   // ============================================================
   // Dataway answers
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         qOut_r     <= 1'b0;
         readWord_r <= 16'h0000;
         lamOut_r   <= 1'b0;
         pass_r     <= 1'b0;
      end
      else
      begin
         lamOut_r <= lamVisible;
         // pass enable on when nothing to send
         pass_r <= renS & ~dataAvail_r;

         if (fTest | fTestClr)
            qOut_r <= lamVisible;
         else if (fRead)
            // no valid data gives no Q
            qOut_r <= readOk;
         else if (fClr)
            qOut_r <= 1'b1;
         else if (s2Rise)
            qOut_r <= 1'b0;

         if (fRead & readOk)
         begin
            if (!seq_r)
               readWord_r <= {5'h00, rndWord[10:0]};
            else if (withHdr)
               readWord_r <= {1'b1, wordCount[3:0], 3'h0, vsn_r};
            else if (compressOn)
               readWord_r <= {1'b0, curIdx[3:0], curWord[10:0]};
            else
               readWord_r <= {5'h00, curWord[10:0]};
         end
      end
   end

   // ============================================================
   // Register port and interrupts
   wire wrCtl   = busWr & (busAddr == `CTL_ADDR);
   wire wrIrqC  = busWr & (busAddr == `IRQ_CLR_ADDR);
   wire wrIrqE  = busWr & (busAddr == `IRQ_EN_ADDR);

   wire [`IRQ_WIDTH-1:0] irqEvents = {zCmd | cCmd | fpRise, seqEnd,
                                      dataReady & lamEn_r};
   wire [`IRQ_WIDTH-1:0] irqClrMask = wrIrqC ?
                                      busWrData[`IRQ_WIDTH-1:0] :
                                      {`IRQ_WIDTH{1'b0}};
   // A new event wins over a clear in the same cycle.
   wire [`IRQ_WIDTH-1:0] irqStatNxt = (irqStat_r & ~irqClrMask) |
                                      irqEvents;
   wire [`IRQ_WIDTH-1:0] irqEnNxt = wrIrqE ?
                                    busWrData[`IRQ_WIDTH-1:0] : irqEn_r;

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ovfSuppress_r <= 1'b0;
         compressEn_r  <= 1'b0;
         ped_r     <= 1'b0;
         seq_r     <= 1'b0;
         lamEn_r   <= 1'b0;
         vsn_r     <= 8'h00;
         irqStat_r <= `IRQ_RESET;
         irqEn_r   <= `IRQ_RESET;
         irq_r     <= 1'b0;
         rdData_r  <= 32'h0000_0000;
      end
      else
      begin
         irqStat_r <= irqStatNxt;
         irqEn_r   <= irqEnNxt;
         irq_r     <= |(irqStatNxt & irqEnNxt);

         if (wrCtl)
         begin
            ovfSuppress_r <= busWrData[`CTL_OVFSUP_BIT];
            compressEn_r  <= busWrData[`CTL_CMPR_BIT];
            ped_r   <= busWrData[`CTL_PED_BIT];
            seq_r   <= busWrData[`CTL_SEQ_BIT];
            lamEn_r <= busWrData[`CTL_LAMEN_BIT];
            vsn_r   <= busWrData[`CTL_VSN_MSB:`CTL_VSN_LSB];
         end
         // Initialize from the dataway overrides a software write.
         if (zCmd)
         begin
            seq_r   <= 1'b1;
            ped_r   <= 1'b1;
            compressEn_r <= 1'b1;
            lamEn_r <= 1'b1;
         end

         rdData_r <= 32'h0000_0000;
         if (busRd)
         begin
            case (busAddr)
               `CTL_ADDR:
                  rdData_r <= {16'h0000, vsn_r, 3'h0, lamEn_r, seq_r,
                               ped_r, compressEn_r, ovfSuppress_r};
               `STAT_ADDR:
                  rdData_r <= {23'h000000, wordCount, 2'h0,
                               dataAvail_r, lamPending_r};
               `IRQ_STAT_ADDR:
                  rdData_r <= {29'h00000000, irqStat_r};
               `IRQ_EN_ADDR:
                  rdData_r <= {29'h00000000, irqEn_r};
               default:
                  rdData_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign busRdData            = rdData_r;
   assign irq                  = irq_r;
   assign lamRequest           = lamOut_r;
   assign qResponse            = qOut_r;
   assign readWord             = readWord_r;
   assign enablePassthroughOut = pass_r;
   assign pedestalSubtract     = ped_r;

endmodule // camac_lam_and_readout_filter
`default_nettype wire

// >>> shared/camac_lam_regs.vh
// Register offsets, field positions, reset values and dataway codes.
`ifndef CAMAC_LAM_REGS_VH
`define CAMAC_LAM_REGS_VH

// ============================================================
// Register byte offsets
`define CTL_ADDR        8'h00
`define STAT_ADDR       8'h04
`define IRQ_STAT_ADDR   8'h08
`define IRQ_CLR_ADDR    8'h0C
`define IRQ_EN_ADDR     8'h10

// ============================================================
// Control register fields
`define CTL_OVFSUP_BIT  0
`define CTL_CMPR_BIT    1
`define CTL_PED_BIT     2
`define CTL_SEQ_BIT     3
`define CTL_LAMEN_BIT   4
`define CTL_VSN_LSB     8
`define CTL_VSN_MSB     15
`define CTL_RESET       16'h0000

// ============================================================
// Status register fields
`define STAT_LAM_BIT    0
`define STAT_AVAIL_BIT  1
`define STAT_WC_LSB     4
`define STAT_WC_MSB     8

// ============================================================
// Interrupt bits
`define IRQ_LAM_BIT     0
`define IRQ_DONE_BIT    1
`define IRQ_CLEAR_BIT   2
`define IRQ_WIDTH       3
`define IRQ_RESET       3'h0

// ============================================================
// Dataway function codes and subaddress
`define FN_READ         5'h02
`define FN_TEST         5'h08
`define FN_CLEAR        5'h09
`define FN_TEST_CLEAR   5'h0A
`define SUBADDR_ZERO    4'h0
`define NO_WORD         5'h10

`endif

// >>> sim/camac_lam_and_readout_filter_chk.sv
// Port checker for the request flag and readout filter.
`default_nettype none
module camac_lam_and_readout_filter_chk
(
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        busWr,
   input wire logic        busRd,
   input wire logic [31:0] busRdData,
   input wire logic        strobeS2,
   input wire logic        initLine,
   input wire logic        clearLine,
   input wire logic        frontClear,
   input wire logic        lamRequest,
   input wire logic        qResponse,
   input wire logic [15:0] readWord,
   input wire logic        readoutEnableIn,
   input wire logic        enablePassthroughOut,
   input wire logic        dataReady,
   input wire logic        pedestalSubtract
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Quiet counter
   // Saturates once the dataway has been idle long enough to settle,
   // since synchronisers delay every strobe by several cycles.
   logic [3:0] quiet_r;
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         quiet_r <= 4'h0;
      else if (strobeS2 || frontClear)
         quiet_r <= 4'h0;
      else if (quiet_r != 4'hF)
         quiet_r <= quiet_r + 4'h1;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // ==========
   // Properties
   property p_rdIdle; !$past(busRd) |-> busRdData == 32'h0; endproperty
   property p_qHold; quiet_r == 4'hF |-> $stable(qResponse); endproperty
   property p_wordHold; quiet_r == 4'hF |-> $stable(readWord); endproperty
   property p_lamFall;
      $fell(lamRequest) |-> quiet_r != 4'hF || $past(busWr) || $past(busWr, 2);
   endproperty
   property p_lamRise;
      $rose(lamRequest) |-> $past(dataReady, 2) || $past(busWr)
         || $past(busWr, 2) || $past(busWr, 3);
   endproperty
   property p_initCfg;
      $rose(strobeS2) && initLine |-> ##[2:6] pedestalSubtract;
   endproperty
   property p_initLam;
      $rose(strobeS2) && (initLine || clearLine) |-> ##[2:6] !lamRequest;
   endproperty
   property p_frontClr; $rose(frontClear) |-> ##[2:6] !lamRequest; endproperty
   property p_passOff;
      !readoutEnableIn [*4] |=> !enablePassthroughOut;
   endproperty

   a_rdIdle: assert property (p_rdIdle)
      else $error("read data not zero outside a read");
   a_qHold: assert property (p_qHold)
      else $error("Q changed without a strobe");
   a_wordHold: assert property (p_wordHold)
      else $error("readout word changed without a strobe");
   a_lamFall: assert property (p_lamFall)
      else $error("request dropped without a clearing event");
   a_lamRise: assert property (p_lamRise)
      else $error("request rose without data ready");
   a_initCfg: assert property (p_initCfg)
      else $error("initialize left pedestal subtraction off");
   a_initLam: assert property (p_initLam)
      else $error("initialize or clear left the request up");
   a_frontClr: assert property (p_frontClr)
      else $error("front clear left the request up");
   a_passOff: assert property (p_passOff)
      else $error("pass output high without enable in");

   c_lamUp: cover property ($rose(lamRequest));
   c_lamDrop: cover property ($fell(lamRequest));
   c_qUp: cover property ($rose(qResponse));
   c_passUp: cover property ($rose(enablePassthroughOut));
endmodule // camac_lam_and_readout_filter_chk

bind camac_lam_and_readout_filter camac_lam_and_readout_filter_chk chk_i (.*);
`default_nettype wire

// >>> sim/crate_ctrl_model.sv
// Crate controller model that drives the dataway command lines.
`default_nettype none
module crate_ctrl_model
(
   input  wire logic       sys_clk,
   output var  logic       stationSel,
   output var  logic       strobeS2,
   output var  logic [4:0] funcCode,
   output var  logic [3:0] subAddr,
   output var  logic       initLine,
   output var  logic       clearLine
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      stationSel = 1'b0;
      strobeS2 = 1'b0;
      funcCode = 5'h00;
      subAddr = 4'h0;
      initLine = 1'b0;
      clearLine = 1'b0;
   end
   // ==========
   // Dataway cycle
   // Lines settle a cycle ahead of S2 so they are stable through the
   // synchronisers when the strobe edge is seen.
   task automatic cmd(input logic [4:0] f, input logic [3:0] a,
                      input logic z, input logic c);
      stationSel <= 1'b1;
      funcCode <= f;
      subAddr <= a;
      initLine <= z;
      clearLine <= c;
      @(posedge sys_clk);
      strobeS2 <= 1'b1;
      repeat (3) @(posedge sys_clk);
      strobeS2 <= 1'b0;
      repeat (3) @(posedge sys_clk);
      // Released function and subaddress lines carry the inverse so a stale code is never reused.
      stationSel <= 1'b0;
      funcCode <= ~f;
      subAddr <= ~a;
      initLine <= 1'b0;
      clearLine <= 1'b0;
      @(posedge sys_clk);
   endtask
endmodule // crate_ctrl_model
`default_nettype wire

// >>> sim/camac_lam_and_readout_filter_tb_top.sv
// Self-checking bench for the request flag and readout filter.
`default_nettype none
`include "camac_lam_regs.vh"
module camac_lam_and_readout_filter_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, rst_n, busWr, busRd, frontClear, readoutEnableIn;
   logic        wordWrite, wordOverflow, dataReady, irq, lamRequest;
   logic        qResponse, enablePassthroughOut, pedestalSubtract;
   logic        stationSel, strobeS2, initLine, clearLine;
   logic [31:0] busWrData, busRdData, rv;
   logic [15:0] readWord;
   logic [10:0] wordValue;
   logic [10:0] val [16];
   logic        ovf [16];
   logic [7:0]  busAddr;
   logic [4:0]  funcCode;
   logic [3:0]  subAddr, wordChan, subIdx;
   int          n_mismatch, cmp_count, seed;

   camac_lam_and_readout_filter dut (.*);
   crate_ctrl_model cc (.*);

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ==========
   // Tasks
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      busAddr <= a;
      busWrData <= d;
      busWr <= 1'b1;
      @(posedge sys_clk);
      busWr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      busAddr <= a;
      busRd <= 1'b1;
      @(posedge sys_clk);
      busRd <= 1'b0;
      #1;
      d = busRdData;
   endtask
   task automatic dw(input logic [4:0] f, input logic [3:0] a,
                     input logic z, input logic c);
      cc.cmd(f, a, z, c);
      #1;
   endtask
   // Zero and overflow words are planted so the filter has work to do.
   task automatic load;
      for (int i = 0; i < 16; i++)
      begin
         val[i] = (i % 4 == 3) ? 11'h000 : 11'($random(seed));
         ovf[i] = (i % 5 == 1);
         wordWrite <= 1'b1;
         wordChan <= 4'(i);
         wordValue <= val[i];
         wordOverflow <= ovf[i];
         @(posedge sys_clk);
      end
      wordWrite <= 1'b0;
      dataReady <= 1'b1;
      @(posedge sys_clk);
      dataReady <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   // Compressed readout gives a header then the kept words with their
   // channel; plain sequential readout gives all sixteen bare values.
   task automatic seqRead(input logic supp, input logic cmpr,
                          input logic [7:0] vsn);
      logic [15:0] q [$];
      foreach (val[i])
         if (!cmpr)
            q.push_back({5'h00, val[i]});
         else if (val[i] != 11'h000 && !(supp && ovf[i]))
            q.push_back({1'b0, 4'(i), val[i]});
      if (cmpr)
         q.push_front({1'b1, 4'(q.size()), 3'h0, vsn});
      foreach (q[k])
      begin
         dw(`FN_READ, 4'h0, 1'b0, 1'b0);
         chk("q", 1, qResponse);
         chk("word", q[k], readWord);
      end
      chk("lam", 0, lamRequest);
      dw(`FN_READ, 4'h0, 1'b0, 1'b0);
      chk("q", 0, qResponse);
   endtask
   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      #200000;
      n_mismatch++;
      final_report;
   end

   // ==========
   // Main sequence
   initial
   begin
      seed = 69894;
      {busWr, busRd, frontClear, wordWrite, wordOverflow, dataReady} = '0;
      {busAddr, busWrData, wordChan, wordValue} = '0;
      readoutEnableIn = 1'b1;
      rst_n = 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      rd(`CTL_ADDR, rv);
      chk("ctl", `CTL_RESET, rv);
      dw(5'h00, 4'h0, 1'b1, 1'b0);
      chk("ped", 1, pedestalSubtract);
      rd(`CTL_ADDR, rv);
      chk("ctl", 32'h1E, rv);
      wr(`IRQ_EN_ADDR, 32'h7);
      for (int m = 0; m < 3; m++)
      begin
         wr(`CTL_ADDR, m == 1 ? 32'hA51B : (m == 0 ? 32'h1E : 32'h1C));
         load;
         chk("lam", 1, lamRequest);
         chk("pass", 0, enablePassthroughOut);
         dw(`FN_TEST, `SUBADDR_ZERO, 1'b0, 1'b0);
         chk("q", 1, qResponse);
         chk("lam", 1, lamRequest);
         seqRead(m == 1, m != 2, m == 1 ? 8'hA5 : 8'h00);
         chk("pass", 1, enablePassthroughOut);
         readoutEnableIn <= 1'b0;
         repeat (5) tick;
         chk("pass", 0, enablePassthroughOut);
         readoutEnableIn <= 1'b1;
      end
      rd(`IRQ_STAT_ADDR, rv);
      chk("irqStat", 32'h7, rv);
      chk("irq", 1, irq);
      wr(`IRQ_EN_ADDR, 32'h0);
      tick;
      chk("irq", 0, irq);
      wr(`IRQ_EN_ADDR, 32'h7);
      wr(`IRQ_CLR_ADDR, 32'h7);
      tick;
      chk("irq", 0, irq);
      rd(8'h20, rv);
      chk("unmapped", 0, rv);
      wr(`CTL_ADDR, 32'h0E);
      load;
      chk("lam", 0, lamRequest);
      dw(`FN_TEST, `SUBADDR_ZERO, 1'b0, 1'b0);
      chk("q", 0, qResponse);
      wr(`CTL_ADDR, 32'h1E);
      tick;
      chk("lam", 1, lamRequest);
      for (int k = 0; k < 2; k++)
      begin
         dw(`FN_TEST_CLEAR, `SUBADDR_ZERO, 1'b0, 1'b0);
         chk("q", k == 0, qResponse);
         chk("lam", 0, lamRequest);
      end
      for (int k = 0; k < 3; k++)
      begin
         load;
         chk("lam", 1, lamRequest);
         if (k == 0)
            dw(5'h00, 4'h0, 1'b0, 1'b1);
         else if (k == 1)
            dw(`FN_CLEAR, `SUBADDR_ZERO, 1'b0, 1'b0);
         else
         begin
            frontClear <= 1'b1;
            repeat (3) tick;
            frontClear <= 1'b0;
            repeat (4) tick;
         end
         chk("lam", 0, lamRequest);
      end
      wr(`CTL_ADDR, 32'h16);
      load;
      for (int j = 0; j < 4; j++)
      begin
         subIdx = 4'($random(seed));
         dw(`FN_READ, subIdx, 1'b0, 1'b0);
         chk("q", 1, qResponse);
         chk("word", {5'h00, val[subIdx]}, readWord);
      end
      dw(5'h01, 4'h0, 1'b0, 1'b0);
      chk("q", 0, qResponse);
      final_report;
   end
endmodule // camac_lam_and_readout_filter_tb_top
`default_nettype wire
